/* File: rtl/sisp_consts.svh */
// Register offsets, field layout and reset values of the switch statistics block
`ifndef SISP_CONSTS_SVH
`define SISP_CONSTS_SVH

`define SISP_IDX_FILT_CNT2   16'h1852
`define SISP_IDX_REGEN_TBL0  16'h1855
`define SISP_IDX_REGEN_TBL1  16'h1856
`define SISP_IDX_REGEN_TBL2  16'h1857
`define SISP_IDX_LRN_CNT0    16'h1858
`define SISP_IDX_LRN_CNT1    16'h1859
`define SISP_ADDR_W          16
`define SISP_DATA_W          32
`define SISP_PRIO_W          3
`define SISP_NUM_PRIO        8
`define SISP_TBL_FIELD_W     24
`define SISP_TBL_RESET       24'hFAC688
`define SISP_CNT_MAX         32'hFFFFFFFF
`define SISP_CNT_RESET       32'h00000000

`endif

/* File: rtl/sisp_pkg.sv */
// Types shared by the switch statistics and priority regeneration block
`default_nettype none
package sisp_pkg;
  typedef struct packed {
    logic       valid;
    logic [1:0] port;
    logic [2:0] prio;
  } sisp_prio_req_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] prio;
  } sisp_prio_ans_t;

  typedef struct packed {
    logic filt_drop_p2;
    logic filt_bcast_p2;
    logic rate_drop_p2;
    logic lrn_disc_p0;
    logic lrn_disc_p1;
  } sisp_events_t;

  typedef enum logic [1:0] {
    SISP_IDLE   = 2'b00,
    SISP_ACCESS = 2'b01
  } sisp_apb_state_t;
endpackage
`default_nettype wire

/* File: rtl/sisp_sat_counter.sv */
// Saturating clear-on-read statistics counter with registered value
`default_nettype none
`include "sisp_consts.svh"
module sisp_sat_counter
  import sisp_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Event and clear
  input  wire logic             inc,
  input  wire logic             clr,
  // Count
  output logic [WIDTH-1:0]      count
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (clr) begin
      // Event in the clearing cycle survives as a count of one
      cnt_next = inc ? WIDTH'(1) : '0;
    end else if (inc && (cnt_reg != {WIDTH{1'b1}})) begin
      cnt_next = cnt_reg + WIDTH'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign count = cnt_reg;

  chk_sat_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (cnt_reg == {WIDTH{1'b1}} && !clr) |=> (cnt_reg == {WIDTH{1'b1}}))
    else $error("saturated counter moved");
  chk_clr_event: assert property (@(posedge pclk) disable iff (!presetn)
    (clr && inc) |=> (cnt_reg == WIDTH'(1)))
    else $error("event lost on clearing read");
endmodule // sisp_sat_counter
`default_nettype wire

/* File: rtl/sisp_switch_stats.sv */
// Switch statistics counters and priority regeneration tables behind an APB slave
// Notes on behaviour
// - A 32-bit counter counts each packet dropped by ingress filtering on port 2.
// - Broadcast throttling drops count too, ingress rate limiting drops do not.
// - Reading the port 2 filtered counter returns the count and then zeroes it.
// - Every counter stops at all ones instead of wrapping.
// - Ports 0, 1 and 2 each own a table mapping received to regenerated priority.
// - The output queue is chosen from the regenerated priority, not the received one.
// - Each table is a read/write word of eight 3-bit entries at bits 3n+2:3n, 31:24 spare.
// - After reset each entry equals its own index, so the map is the identity.
// - Ports 0 and 1 each count source addresses not learned for lack of table space.
// - Reading a learn discard counter returns the count and then zeroes it.
`default_nettype none
`include "sisp_consts.svh"
module sisp_switch_stats
  import sisp_pkg::*;
#(
  parameter int CNT_W = `SISP_DATA_W
) (
  // APB clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`SISP_ADDR_W-1:0] paddr,
  input  wire logic [`SISP_DATA_W-1:0] pwdata,
  output logic      [`SISP_DATA_W-1:0] prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Count events from the switch engine
  input  wire sisp_events_t            events,
  // Priority lookup for queue selection
  input  wire sisp_prio_req_t          prio_req,
  output sisp_prio_ans_t               prio_ans
);
  // Byte address is four times the printed register index
  function automatic logic [`SISP_ADDR_W-1:0] byte_addr(input logic [`SISP_ADDR_W-1:0] idx);
    byte_addr = {idx[`SISP_ADDR_W-3:0], 2'b00};
  endfunction

  function automatic logic [2:0] table_entry(input logic [`SISP_TBL_FIELD_W-1:0] tbl,
                                             input logic [2:0] prio);
    table_entry = tbl[prio*3 +: 3];
  endfunction

  // Counters narrower than the bus read back zero-extended
  function automatic logic [`SISP_DATA_W-1:0] cnt_word(input logic [CNT_W-1:0] c);
    cnt_word              = '0;
    cnt_word[CNT_W-1:0]   = c;
  endfunction

  localparam logic [`SISP_ADDR_W-1:0] A_FILT2 = `SISP_IDX_FILT_CNT2 << 2;
  localparam logic [`SISP_ADDR_W-1:0] A_TBL0  = `SISP_IDX_REGEN_TBL0 << 2;
  localparam logic [`SISP_ADDR_W-1:0] A_TBL1  = `SISP_IDX_REGEN_TBL1 << 2;
  localparam logic [`SISP_ADDR_W-1:0] A_TBL2  = `SISP_IDX_REGEN_TBL2 << 2;
  localparam logic [`SISP_ADDR_W-1:0] A_LRN0  = `SISP_IDX_LRN_CNT0 << 2;
  localparam logic [`SISP_ADDR_W-1:0] A_LRN1  = `SISP_IDX_LRN_CNT1 << 2;

  // APB handshake state
  sisp_apb_state_t            st_reg;
  sisp_apb_state_t            st_next;
  logic [`SISP_DATA_W-1:0]    prdata_reg;
  logic [`SISP_DATA_W-1:0]    prdata_next;
  logic                       pready_reg;
  logic                       pready_next;
  logic                       pslverr_reg;
  logic                       pslverr_next;

  // Priority tables
  logic [`SISP_TBL_FIELD_W-1:0] tbl_reg  [3];
  logic [`SISP_TBL_FIELD_W-1:0] tbl_next [3];

  // Priority answer
  sisp_prio_ans_t             ans_reg;
  sisp_prio_ans_t             ans_next;

  // Counter events and clears
  logic                       filt_inc;
  logic                       clr_filt;
  logic                       clr_lrn0;
  logic                       clr_lrn1;
  logic [CNT_W-1:0]           filt_cnt;
  logic [CNT_W-1:0]           lrn0_cnt;
  logic [CNT_W-1:0]           lrn1_cnt;

  logic                       acc;
  logic                       rd_acc;
  logic                       wr_acc;

  // Access phase is taken in the cycle after setup; one wait state gives a registered prdata
  assign acc    = psel && penable && (st_reg == SISP_ACCESS) && !pready_reg;
  assign rd_acc = acc && !pwrite;
  assign wr_acc = acc && pwrite;

  // Rate limiting drops are tallied elsewhere and never reach this counter
  assign filt_inc = events.filt_drop_p2 || events.filt_bcast_p2;

  // Clear happens on the same edge that hands read data out
  assign clr_filt = rd_acc && (paddr == byte_addr(`SISP_IDX_FILT_CNT2));
  assign clr_lrn0 = rd_acc && (paddr == A_LRN0);
  assign clr_lrn1 = rd_acc && (paddr == A_LRN1);

  sisp_sat_counter #(.WIDTH(CNT_W)) u_filt2 (
    .pclk    (pclk),
    .presetn (presetn),
    .inc     (filt_inc),
    .clr     (clr_filt),
    .count   (filt_cnt)
  );

  sisp_sat_counter #(.WIDTH(CNT_W)) u_lrn0 (
    .pclk    (pclk),
    .presetn (presetn),
    .inc     (events.lrn_disc_p0),
    .clr     (clr_lrn0),
    .count   (lrn0_cnt)
  );

  sisp_sat_counter #(.WIDTH(CNT_W)) u_lrn1 (
    .pclk    (pclk),
    .presetn (presetn),
    .inc     (events.lrn_disc_p1),
    .clr     (clr_lrn1),
    .count   (lrn1_cnt)
  );

  // APB next state and read data
  always_comb begin
    st_next      = st_reg;
    prdata_next  = '0;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    for (int i = 0; i < 3; i++) begin
      tbl_next[i] = tbl_reg[i];
    end
    case (st_reg)
      SISP_IDLE: begin
        if (psel && !penable) begin
          st_next = SISP_ACCESS;
        end
      end
      SISP_ACCESS: begin
        if (acc) begin
          pready_next = 1'b1;
          if (paddr == A_FILT2) begin
            prdata_next = cnt_word(filt_cnt);
          end else if (paddr == A_TBL0) begin
            prdata_next = {8'h00, tbl_reg[0]};
            if (pwrite) tbl_next[0] = pwdata[`SISP_TBL_FIELD_W-1:0];
          end else if (paddr == A_TBL1) begin
            prdata_next = {8'h00, tbl_reg[1]};
            if (pwrite) tbl_next[1] = pwdata[`SISP_TBL_FIELD_W-1:0];
          end else if (paddr == A_TBL2) begin
            prdata_next = {8'h00, tbl_reg[2]};
            if (pwrite) tbl_next[2] = pwdata[`SISP_TBL_FIELD_W-1:0];
          end else if (paddr == A_LRN0) begin
            prdata_next = cnt_word(lrn0_cnt);
          end else if (paddr == A_LRN1) begin
            prdata_next = cnt_word(lrn1_cnt);
          end else begin
            pslverr_next = 1'b1;
          end
          // A write answers with zero data; counters ignore it
          if (pwrite) begin
            prdata_next = '0;
          end
        end else if (pready_reg) begin
          st_next = (psel && !penable) ? SISP_ACCESS : SISP_IDLE;
        end else if (!psel) begin
          st_next = SISP_IDLE;
        end
      end
      default: begin
        st_next = SISP_IDLE;
      end
    endcase
  end

  // Priority regeneration used by queue selection
  always_comb begin
    ans_next.valid = prio_req.valid;
    ans_next.prio  = '0;
    if (prio_req.port < 2'd3) begin
      ans_next.prio = table_entry(tbl_reg[prio_req.port], prio_req.prio);
    end else begin
      ans_next.valid = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg      <= SISP_IDLE;
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      ans_reg     <= '0;
      for (int i = 0; i < 3; i++) begin
        tbl_reg[i] <= `SISP_TBL_RESET;
      end
    end else begin
      st_reg      <= st_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      ans_reg     <= ans_next;
      for (int i = 0; i < 3; i++) begin
        tbl_reg[i] <= tbl_next[i];
      end
    end
  end

  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign prio_ans = ans_reg;

  chk_tbl_reset: assert property (@(posedge pclk)
    $rose(presetn) |-> (tbl_reg[0] == `SISP_TBL_RESET && tbl_reg[1] == `SISP_TBL_RESET &&
      tbl_reg[2] == `SISP_TBL_RESET))
    else $error("table not identity after reset");
  chk_regen_used: assert property (@(posedge pclk) disable iff (!presetn)
    (prio_req.valid && prio_req.port == 2'd1) |=>
      (prio_ans.prio == $past(tbl_reg[1][prio_req.prio*3 +: 3])))
    else $error("queue priority not regenerated");
  chk_filt_rd_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_filt && !filt_inc) |=> (filt_cnt == '0 && prdata == $past(filt_cnt)))
    else $error("filtered counter not cleared on read");
  chk_lrn_rd_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_lrn0 && !events.lrn_disc_p0) |=> (lrn0_cnt == '0))
    else $error("learn counter not cleared on read");
  chk_filt_count: assert property (@(posedge pclk) disable iff (!presetn)
    (events.rate_drop_p2 && !filt_inc && !clr_filt) |=> $stable(filt_cnt))
    else $error("rate drop counted");
  chk_bcast_count: assert property (@(posedge pclk) disable iff (!presetn)
    (events.filt_bcast_p2 && !clr_filt && filt_cnt != '1) |=>
      (filt_cnt == $past(filt_cnt) + CNT_W'(1)))
    else $error("filtered drop not counted");
  chk_resv_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && $past(rd_acc) && $past(paddr) == A_TBL1) |-> (prdata[31:24] == 8'h00))
    else $error("reserved bits not zero");
  chk_tbl_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == A_TBL2) |=> (tbl_reg[2] == $past(pwdata[23:0])))
    else $error("table write lost");
  chk_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) ##1 (psel && penable) |=> pready)
    else $error("answer not after one wait");

  // Regeneration lookups
  chk_regen_port0: assert property (@(posedge pclk) disable iff (!presetn)
    (prio_req.valid && prio_req.port == 2'd0) |=>
      (prio_ans.prio == $past(tbl_reg[0][prio_req.prio*3 +: 3])))
    else $error("port 0 priority not regenerated");
  chk_regen_port2: assert property (@(posedge pclk) disable iff (!presetn)
    (prio_req.valid && prio_req.port == 2'd2) |=>
      (prio_ans.prio == $past(tbl_reg[2][prio_req.prio*3 +: 3])))
    else $error("port 2 priority not regenerated");
  chk_ans_valid: assert property (@(posedge pclk) disable iff (!presetn)
    (prio_req.valid && prio_req.port != 2'd3) |=> prio_ans.valid)
    else $error("lookup answer missing");
  chk_bad_port: assert property (@(posedge pclk) disable iff (!presetn)
    (prio_req.port == 2'd3) |=> !prio_ans.valid)
    else $error("answer for a port without a table");
  chk_ans_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !prio_req.valid |=> !prio_ans.valid)
    else $error("answer without a request");

  // Table storage
  chk_tbl0_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == A_TBL0) |=> (tbl_reg[0] == $past(pwdata[23:0])))
    else $error("table 0 write lost");
  chk_tbl1_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == A_TBL1) |=> (tbl_reg[1] == $past(pwdata[23:0])))
    else $error("table 1 write lost");
  chk_tbl0_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_acc && paddr == A_TBL0) |=> $stable(tbl_reg[0]))
    else $error("table 0 changed without a write");
  chk_tbl1_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_acc && paddr == A_TBL1) |=> $stable(tbl_reg[1]))
    else $error("table 1 changed without a write");
  chk_tbl2_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_acc && paddr == A_TBL2) |=> $stable(tbl_reg[2]))
    else $error("table 2 changed without a write");
  chk_tbl_rd_data: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == A_TBL0) |=> (prdata == {8'h00, $past(tbl_reg[0])}))
    else $error("table read data wrong");
  chk_resv_tbl2: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == A_TBL2) |=> (prdata[31:24] == 8'h00))
    else $error("reserved bits of table 2 not zero");

  // Counters
  chk_lrn1_rd_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_lrn1 && !events.lrn_disc_p1) |=> (lrn1_cnt == '0))
    else $error("port 1 learn counter not cleared on read");
  chk_lrn0_count: assert property (@(posedge pclk) disable iff (!presetn)
    (events.lrn_disc_p0 && !clr_lrn0 && lrn0_cnt != '1) |=>
      (lrn0_cnt == $past(lrn0_cnt) + CNT_W'(1)))
    else $error("port 0 learn discard not counted");
  chk_lrn1_count: assert property (@(posedge pclk) disable iff (!presetn)
    (events.lrn_disc_p1 && !clr_lrn1 && lrn1_cnt != '1) |=>
      (lrn1_cnt == $past(lrn1_cnt) + CNT_W'(1)))
    else $error("port 1 learn discard not counted");
  chk_lrn0_rd_data: assert property (@(posedge pclk) disable iff (!presetn)
    clr_lrn0 |=> (prdata == $past(lrn0_cnt)))
    else $error("port 0 learn count not returned");
  chk_lrn1_rd_data: assert property (@(posedge pclk) disable iff (!presetn)
    clr_lrn1 |=> (prdata == $past(lrn1_cnt)))
    else $error("port 1 learn count not returned");
  chk_filt_sat: assert property (@(posedge pclk) disable iff (!presetn)
    (filt_cnt == '1 && !clr_filt) |=> (filt_cnt == '1))
    else $error("filtered counter left saturation");
  chk_lrn0_sat: assert property (@(posedge pclk) disable iff (!presetn)
    (lrn0_cnt == '1 && !clr_lrn0) |=> (lrn0_cnt == '1))
    else $error("port 0 learn counter left saturation");
  chk_lrn1_sat: assert property (@(posedge pclk) disable iff (!presetn)
    (lrn1_cnt == '1 && !clr_lrn1) |=> (lrn1_cnt == '1))
    else $error("port 1 learn counter left saturation");
  chk_filt_wr_ign: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == A_FILT2 && !filt_inc) |=> $stable(filt_cnt))
    else $error("write changed filtered counter");
  chk_lrn0_wr_ign: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == A_LRN0 && !events.lrn_disc_p0) |=> $stable(lrn0_cnt))
    else $error("write changed port 0 learn counter");
  chk_filt_clr_evt: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_filt && filt_inc) |=> (filt_cnt == CNT_W'(1)))
    else $error("filtered event lost on clearing read");

  // Bus answers
  chk_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_wr_rdata: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc |=> (prdata == '0))
    else $error("write answered with data");
  chk_err_no_data: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> (prdata == '0))
    else $error("error answer carries data");
  chk_err_no_write: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && pslverr_next) |=>
      ($stable(tbl_reg[0]) && $stable(tbl_reg[1]) && $stable(tbl_reg[2])))
    else $error("unmapped access changed a table");

  cov_read_filt: cover property (@(posedge pclk) disable iff (!presetn) clr_filt);
  cov_clr_evt:   cover property (@(posedge pclk) disable iff (!presetn) clr_lrn1 && events.lrn_disc_p1);
  cov_tbl_write: cover property (@(posedge pclk) disable iff (!presetn) wr_acc && paddr == A_TBL0);
  cov_err:       cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  cov_saturated: cover property (@(posedge pclk) disable iff (!presetn) filt_cnt == '1);
endmodule // sisp_switch_stats
`default_nettype wire

/* File: bench/sisp_switch_stats_bench.sv */
// Self-checking bench for the switch statistics and priority regeneration block
`default_nettype none
`include "sisp_consts.svh"
module sisp_switch_stats_bench import sisp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Short counters so saturation is reachable in a short run
  localparam int           CW     = 4;
  localparam sisp_events_t E_DROP = 5'b10000;
  localparam sisp_events_t E_BC   = 5'b01000;
  localparam sisp_events_t E_RATE = 5'b00100;
  localparam sisp_events_t E_L0   = 5'b00010;
  localparam sisp_events_t E_L1   = 5'b00001;
  logic           pclk = 1'b0;
  logic           presetn;
  logic           psel, penable, pwrite, pslverr, pready;
  logic [15:0]    paddr, a_filt, a_l0, a_l1;
  logic [31:0]    pwdata, prdata, rdata;
  logic           rerr;
  sisp_events_t   events;
  sisp_prio_req_t prio_req;
  sisp_prio_ans_t prio_ans;
  logic [15:0]    tbl_a [3];
  int             kx [3] = '{7, 1, 3};
  int             n_mismatch = 0;
  int             tests_run = 0;

  sisp_switch_stats #(.CNT_W(CW)) u_sisp_switch_stats (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .events(events), .prio_req(prio_req), .prio_ans(prio_ans));

  always #20 pclk = ~pclk;

  function automatic logic [15:0] ba(input logic [15:0] i);
    ba = {i[13:0], 2'b00};
  endfunction
  // Table word whose entry n holds n xor k
  function automatic logic [31:0] tbl(input int k);
    tbl = '0;
    for (int n = 0; n < 8; n++) tbl[3*n +: 3] = 3'(n ^ k);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One APB transfer; ev pulses in the taking cycle
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input sisp_events_t ev);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1; events <= ev;
    n = 0;
    do begin
      @(posedge pclk);
      events <= '0;
      n++;
    end while (pready !== 1'b1);
    rdata = prdata; rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // Access phase is expected to last exactly two cycles
    check(32'(n), 32'h2);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, '0);
    check(rdata, exp);
    check({31'h0, rerr}, 32'h0);
  endtask

  task automatic pulse(input sisp_events_t ev, input int n);
    repeat (n) begin
      @(posedge pclk);
      events <= ev;
    end
    @(posedge pclk);
    events <= '0;
  endtask

  task automatic look(input logic [1:0] pt, input logic [2:0] pr, input logic [3:0] exp);
    @(posedge pclk);
    prio_req <= {1'b1, pt, pr};
    @(posedge pclk);
    prio_req <= '0;
    @(posedge pclk);
    check(pt == 2'd3 ? {31'h0, prio_ans.valid} : {28'h0, prio_ans}, {28'h0, exp});
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; events = '0; prio_req = '0;
    a_filt = ba(`SISP_IDX_FILT_CNT2); a_l0 = ba(`SISP_IDX_LRN_CNT0);
    a_l1 = ba(`SISP_IDX_LRN_CNT1);
    tbl_a = '{ba(`SISP_IDX_REGEN_TBL0), ba(`SISP_IDX_REGEN_TBL1), ba(`SISP_IDX_REGEN_TBL2)};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      rd(tbl_a[p], tbl(0));
      for (int n = 0; n < 8; n++) look(2'(p), 3'(n), {1'b1, 3'(n)});
    end
    rd(a_filt, 32'h0);
    rd(a_l0, 32'h0);
    rd(a_l1, 32'h0);
    $display("test reset_values done");
    // Reserved byte set on purpose; must not stick
    for (int p = 0; p < 3; p++) begin
      apb(1'b1, tbl_a[p], 32'hFF000000 | tbl(kx[p]), '0);
      rd(tbl_a[p], tbl(kx[p]));
    end
    for (int p = 0; p < 3; p++)
      for (int n = 0; n < 8; n++) look(2'(p), 3'(n), {1'b1, 3'(n ^ kx[p])});
    look(2'd3, 3'd5, 4'h0);
    $display("test regen_tables done");
    pulse(E_DROP, 3); pulse(E_BC, 2); pulse(E_DROP | E_BC, 1); pulse(E_RATE, 4);
    apb(1'b1, a_filt, 32'hFFFFFFFF, '0);
    check({31'h0, rerr}, 32'h0);
    rd(a_filt, 32'h6);
    rd(a_filt, 32'h0);
    pulse(E_L0, 2); pulse(E_L1, 5);
    apb(1'b1, a_l0, 32'hFFFFFFFF, '0);
    rd(a_l0, 32'h2);
    rd(a_l1, 32'h5);
    rd(a_l0, 32'h0);
    $display("test counters done");
    pulse(E_DROP, 20); pulse(E_L0 | E_L1, 17);
    rd(a_filt, 32'hF);
    rd(a_l0, 32'hF);
    rd(a_l1, 32'hF);
    $display("test saturation done");
    pulse(E_DROP | E_L1, 3);
    apb(1'b0, a_filt, 32'h0, E_DROP);
    check(rdata, 32'h3);
    apb(1'b0, a_l1, 32'h0, E_L1);
    check(rdata, 32'h3);
    rd(a_filt, 32'h1);
    rd(a_l1, 32'h1);
    $display("test clear_collision done");
    // Unmapped slot between counter and tables
    apb(1'b1, ba(16'h1854), 32'h12345678, '0);
    check({31'h0, rerr}, 32'h1);
    apb(1'b0, ba(16'h1854), 32'h0, '0);
    check(rdata, 32'h0);
    check({31'h0, rerr}, 32'h1);
    rd(tbl_a[0], tbl(kx[0]));
    $display("test unmapped done");
    // Reset in mid-run must restore identity tables and empty counters
    pulse(E_DROP | E_L0, 2);
    apb(1'b1, tbl_a[1], 32'h0, '0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(tbl_a[0], tbl(0));
    rd(tbl_a[1], tbl(0));
    look(2'd1, 3'd6, 4'hE);
    rd(a_filt, 32'h0);
    rd(a_l0, 32'h0);
    $display("test midrun_reset done");
    report_and_stop();
  end
endmodule // sisp_switch_stats_bench
`default_nettype wire
